// ---- bench/link_master.sv ----
// Single-wire bus master with strap resistor, far side of the divider pin
`timescale 1ns/1ps
module link_master (
  input wire logic ref_clk,
  input wire logic devOut,
  input wire logic devOe,
  output logic wireLevel
);
  logic masterLow = 1'b0;
  logic pullHigh = 1'b0;

  // Pull-up only fitted for programming; otherwise the pin settles low
  assign wireLevel = devOe ? devOut : (!masterLow && pullHigh);

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Counts low cycles of the answer after a long low pulse
  task automatic initSeq(output int presLow);
    presLow = 0;
    masterLow <= 1'b1;
    idle(500);
    masterLow <= 1'b0;
    // Sampled mid-cycle, away from the edges that move the pin
    for (int t = 0; t < 400; t++)
    begin
      @(negedge ref_clk);
      presLow += int'(!wireLevel);
    end
    idle(1);
  endtask

  // Every slot opens with a falling edge; late release means a zero
  task automatic writeBit(input logic b);
    masterLow <= 1'b1;
    idle(b ? 5 : 45);
    masterLow <= 1'b0;
    idle(b ? 45 : 5);
  endtask

  task automatic sendCmd(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      writeBit(v[i]);
  endtask

  task automatic sendWord(input logic [8:0] v);
    for (int i = 0; i < 9; i++)
      writeBit(v[i]);
  endtask

  // Short low start, then sample well before the device lets go
  task automatic readWord(output logic [8:0] v);
    for (int i = 0; i < 9; i++)
    begin
      masterLow <= 1'b1;
      idle(2);
      masterLow <= 1'b0;
      idle(12);
      @(negedge ref_clk);
      v[i] = wireLevel;
      idle(36);
    end
  endtask
endmodule

// ---- bench/tb.sv ----
// Testbench for the programmable oscillator divider
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic factoryInit = 1'b1;
  logic pinOut;
  logic pinOe;
  logic progMode;
  logic wireLevel;
  int nErrors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 ref_clk = ~ref_clk;

  // Short stabilisation keeps each power cycle cheap
  programmable_osc_divider #(.STAB_CYCLES(8)) i_dut (
    .ref_clk(ref_clk),
    .srst(srst),
    .factoryInit(factoryInit),
    .pinIn(wireLevel),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .progMode(progMode)
  );

  link_master i_master (
    .ref_clk(ref_clk),
    .devOut(pinOut),
    .devOe(pinOe),
    .wireLevel(wireLevel)
  );

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      nErrors++;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Strap level must hold over the first edge after reset release
  task automatic powerUp(input logic prog);
    @(posedge ref_clk);
    i_master.pullHigh <= prog;
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (14) @(posedge ref_clk);
    check("mode strap", 9'(progMode), 9'(prog));
    check("pin enable", 9'(pinOe), 9'(!prog));
  endtask

  task automatic access(input logic [7:0] cmd, input logic [8:0] word);
    int presLow;
    logic [8:0] got;
    i_master.initSeq(presLow);
    check("presence length", 9'(presLow), 9'h078);
    i_master.sendCmd(cmd);
    if (cmd[7])
    begin
      i_master.readWord(got);
      check("read word", got, word);
    end
    else
      i_master.sendWord(word);
  endtask

  // Rising edges sampled mid-cycle; two full periods averaged
  task automatic period(input logic [8:0] exp);
    int rises;
    int first;
    int last;
    logic prev;
    rises = 0;
    first = 0;
    last = 0;
    prev = pinOut;
    for (int t = 0; t < 3000 && rises < 3; t++)
    begin
      @(negedge ref_clk);
      if (pinOut && !prev)
      begin
        rises++;
        if (rises == 1)
          first = t;
        last = t;
      end
      prev = pinOut;
    end
    check("clock period", 9'((last - first) / 2), exp);
  endtask

  task automatic factoryDefault();
    powerUp(1'b0);
    period(9'h002);
  endtask

  task automatic programSession();
    powerUp(1'b1);
    access(8'h01, 9'h005);
    access(8'hA1, 9'h005);
    access(8'h02, 9'h030);
    access(8'hA2, 9'h030);
    access(8'hC3, 9'h1FF);
    access(8'hA1, 9'h005);
    period(9'h000);
  endtask

  task automatic prescaleModes();
    powerUp(1'b0);
    period(9'h01C);
    powerUp(1'b1);
    access(8'h02, 9'h038);
    powerUp(1'b0);
    period(9'h00E);
    powerUp(1'b1);
    access(8'h02, 9'h034);
    powerUp(1'b0);
    period(9'h007);
  endtask

  task automatic directRoute();
    powerUp(1'b1);
    access(8'h02, 9'h032);
    powerUp(1'b0);
    @(posedge ref_clk);
    #2;
    check("direct high", 9'(pinOut), 9'h001);
    #5;
    check("direct low", 9'(pinOut), 9'h000);
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk);
    factoryInit <= 1'b0;
    srst <= 1'b0;
    factoryDefault();
    programSession();
    prescaleModes();
    directRoute();
    stop_test();
  end
endmodule

// ---- src/osc_div_cfg.svh ----
// Constants for the programmable oscillator divider
`ifndef OSC_DIV_CFG_SVH
`define OSC_DIV_CFG_SVH
`define CLK_NS 10
`define STAB_CYC 1024
`define RST_LOW_NS 4800
`define PRES_WAIT_NS 300
`define PRES_LOW_NS 1200
`define SAMPLE_NS 300
`define RST_LOW_CYC ((`RST_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define PRES_WAIT_CYC ((`PRES_WAIT_NS + `CLK_NS - 1) / `CLK_NS)
`define PRES_LOW_CYC ((`PRES_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define SAMPLE_CYC ((`SAMPLE_NS + `CLK_NS - 1) / `CLK_NS)
`define DIRECT_BIT 1
`define SKIP_BIT 2
`define RATIO_BIT 3
`define COUNT_DEFAULT 9'h000
`define PRESCALE_DEFAULT 9'h034
`define COUNT_MAX 9'h1FF
`define PRESCALE_MAX 9'h030
`define CMD_WR_COUNT 8'h01
`define CMD_WR_PRESCALE 8'h02
`define CMD_RD_COUNT 8'hA1
`define CMD_RD_PRESCALE 8'hA2
`define CMD_LAST_BIT 4'h7
`define DATA_LAST_BIT 4'h8
`endif

// ---- src/osc_div_pkg.sv ----
// Types for the programmable oscillator divider
package osc_div_pkg;
  typedef enum logic [7:0] {
    ST_POR = 8'h01,
    ST_RUN = 8'h02,
    ST_PIDLE = 8'h04,
    ST_PWAIT = 8'h08,
    ST_PRES = 8'h10,
    ST_CMD = 8'h20,
    ST_DATA = 8'h40,
    ST_IGNORE = 8'h80
  } state_t;
endpackage

// ---- src/programmable_osc_divider.sv ----
// Oscillator divider core with single-wire configuration port
`timescale 1ns/1ps
`include "osc_div_cfg.svh"
module programmable_osc_divider #(
  parameter int STAB_CYCLES = `STAB_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic factoryInit,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic progMode
);
  osc_div_pkg::state_t state_reg;
  logic [11:0] stabCnt_reg;
  logic modeProg_reg;
  logic [8:0] nvCount_reg;
  logic [8:0] nvPrescale_reg;
  logic [8:0] workCount_reg;
  logic [8:0] workPrescale_reg;
  logic lineReg;
  logic [11:0] lowCnt_reg;
  logic [11:0] slotCnt_reg;
  logic slotAct_reg;
  logic [3:0] bitCnt_reg;
  logic [8:0] shift_reg;
  logic isRead_reg;
  logic isPrescale_reg;
  logic [11:0] periodCnt_reg;
  logic clkOut_reg;
  logic [11:0] divisor;
  logic stabDone;
  logic fall;
  logic rise;
  logic resetSeen;
  logic sampleNow;
  logic cmdDone;
  logic [7:0] cmdByte;
  logic [8:0] commitData;
  logic commitNow;
  logic runMode;
  logic directOn;
  logic progBus;

  assign runMode = state_reg == osc_div_pkg::ST_RUN;
  assign stabDone = state_reg == osc_div_pkg::ST_POR && stabCnt_reg == 12'(STAB_CYCLES - 1);
  assign progMode = modeProg_reg;
  assign fall = lineReg && !pinIn;
  assign rise = !lineReg && pinIn;
  assign progBus = state_reg inside {osc_div_pkg::ST_PIDLE, osc_div_pkg::ST_CMD,
                                     osc_div_pkg::ST_DATA, osc_div_pkg::ST_IGNORE};
  assign resetSeen = progBus && rise && lowCnt_reg >= 12'(`RST_LOW_CYC);
  assign sampleNow = slotAct_reg && slotCnt_reg == 12'(`SAMPLE_CYC - 1);
  assign cmdByte = {pinIn, shift_reg[8:2]};
  assign cmdDone = state_reg == osc_div_pkg::ST_CMD && sampleNow
                   && bitCnt_reg == `CMD_LAST_BIT;
  assign commitData = {pinIn, shift_reg[8:1]};
  assign commitNow = state_reg == osc_div_pkg::ST_DATA && sampleNow && !isRead_reg
                     && bitCnt_reg == `DATA_LAST_BIT;

  // Power-up stabilisation timer and mode strap
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      stabCnt_reg <= 12'h000;
      modeProg_reg <= 1'b0;
    end
    else if (state_reg == osc_div_pkg::ST_POR)
    begin
      stabCnt_reg <= stabCnt_reg + 12'h001;
      // Strap caught on the first clock after release
      if (stabCnt_reg == 12'h000)
        modeProg_reg <= pinIn;
    end
  end

  // Nonvolatile words survive srst; only the factory load and committed writes set them
  always_ff @(posedge ref_clk)
  begin
    if (factoryInit)
    begin
      nvCount_reg <= `COUNT_DEFAULT;
      nvPrescale_reg <= `PRESCALE_DEFAULT;
    end
    else if (commitNow)
    begin
      if (isPrescale_reg)
        nvPrescale_reg <= commitData;
      else
        nvCount_reg <= commitData;
    end
  end

  // Working copy: forced to maximum, loaded once after stabilisation unless strapped for programming
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      workCount_reg <= `COUNT_MAX;
      workPrescale_reg <= `PRESCALE_MAX;
    end
    else if (stabDone && !modeProg_reg)
    begin
      workCount_reg <= nvCount_reg;
      workPrescale_reg <= nvPrescale_reg;
    end
  end

  // Field positions follow the layout the master writes
  assign directOn = workPrescale_reg[`DIRECT_BIT];

  always_comb
  begin
    divisor = {3'h0, workCount_reg} + 12'h002;
    if (!workPrescale_reg[`SKIP_BIT])
      divisor = workPrescale_reg[`RATIO_BIT] ? divisor << 1 : divisor << 2;
  end

  // Total divisor counter; odd divisors give a slightly short high phase
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      periodCnt_reg <= 12'h000;
      clkOut_reg <= 1'b0;
    end
    else
    begin
      if (periodCnt_reg >= divisor - 12'h001)
        periodCnt_reg <= 12'h000;
      else
        periodCnt_reg <= periodCnt_reg + 12'h001;
      clkOut_reg <= periodCnt_reg < (divisor >> 1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      lineReg <= 1'b1;
      lowCnt_reg <= 12'h000;
    end
    else
    begin
      lineReg <= pinIn;
      if (pinIn)
        lowCnt_reg <= 12'h000;
      else if (lowCnt_reg != 12'hFFF)
        lowCnt_reg <= lowCnt_reg + 12'h001;
    end
  end

  // Programming sequencer; a reset pulse restarts any access
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg <= osc_div_pkg::ST_POR;
      slotCnt_reg <= 12'h000;
      slotAct_reg <= 1'b0;
      bitCnt_reg <= 4'h0;
      shift_reg <= 9'h000;
      isRead_reg <= 1'b0;
      isPrescale_reg <= 1'b0;
    end
    else if (resetSeen)
    begin
      state_reg <= osc_div_pkg::ST_PWAIT;
      slotCnt_reg <= 12'h000;
      slotAct_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        osc_div_pkg::ST_POR:
        begin
          if (stabDone)
            state_reg <= modeProg_reg ? osc_div_pkg::ST_PIDLE : osc_div_pkg::ST_RUN;
        end
        osc_div_pkg::ST_RUN, osc_div_pkg::ST_PIDLE, osc_div_pkg::ST_IGNORE:
        begin
          slotAct_reg <= 1'b0;
        end
        osc_div_pkg::ST_PWAIT:
        begin
          if (slotCnt_reg == 12'(`PRES_WAIT_CYC - 1))
          begin
            state_reg <= osc_div_pkg::ST_PRES;
            slotCnt_reg <= 12'h000;
          end
          else
            slotCnt_reg <= slotCnt_reg + 12'h001;
        end
        osc_div_pkg::ST_PRES:
        begin
          if (slotCnt_reg == 12'(`PRES_LOW_CYC - 1))
          begin
            state_reg <= osc_div_pkg::ST_CMD;
            slotCnt_reg <= 12'h000;
            bitCnt_reg <= 4'h0;
          end
          else
            slotCnt_reg <= slotCnt_reg + 12'h001;
        end
        osc_div_pkg::ST_CMD, osc_div_pkg::ST_DATA:
        begin
          if (fall && !slotAct_reg)
          begin
            slotAct_reg <= 1'b1;
            slotCnt_reg <= 12'h000;
          end
          else if (sampleNow)
            slotAct_reg <= 1'b0;
          else if (slotAct_reg)
            slotCnt_reg <= slotCnt_reg + 12'h001;
          if (sampleNow)
          begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (state_reg == osc_div_pkg::ST_CMD)
              shift_reg <= {pinIn, shift_reg[8:1]};
            else if (isRead_reg)
              shift_reg <= {1'b1, shift_reg[8:1]};
            else
              shift_reg <= commitData;
          end
          if (cmdDone)
          begin
            bitCnt_reg <= 4'h0;
            isRead_reg <= cmdByte[7];
            isPrescale_reg <= cmdByte[1];
            unique case (cmdByte)
              `CMD_WR_COUNT, `CMD_WR_PRESCALE:
                state_reg <= osc_div_pkg::ST_DATA;
              `CMD_RD_COUNT:
              begin
                state_reg <= osc_div_pkg::ST_DATA;
                shift_reg <= nvCount_reg;
              end
              `CMD_RD_PRESCALE:
              begin
                state_reg <= osc_div_pkg::ST_DATA;
                shift_reg <= nvPrescale_reg;
              end
              default:
                state_reg <= osc_div_pkg::ST_IGNORE;
            endcase
          end
          if (state_reg == osc_div_pkg::ST_DATA && sampleNow
              && bitCnt_reg == `DATA_LAST_BIT)
            state_reg <= osc_div_pkg::ST_IGNORE;
        end
        default:
          state_reg <= osc_div_pkg::ST_POR;
      endcase
    end
  end

  // Pin is the clock in run mode, an open-drain data line otherwise
  assign pinOe = runMode
                 || state_reg == osc_div_pkg::ST_PRES
                 || (state_reg == osc_div_pkg::ST_DATA && isRead_reg
                     && slotAct_reg && !shift_reg[0]);
  // Direct route forwards the oscillator itself, so no flop in that path
  assign pinOut = runMode && (directOn ? ref_clk : clkOut_reg);

  sequence presencePulse;
    (state_reg == osc_div_pkg::ST_PWAIT && !pinOe) ##30
    (state_reg == osc_div_pkg::ST_PRES && pinOe) ##119
    (state_reg == osc_div_pkg::ST_PRES && pinOe) ##1
    (state_reg == osc_div_pkg::ST_CMD);
  endsequence

  property resetToPresence;
    @(posedge ref_clk) disable iff (srst)
    resetSeen |=> presencePulse;
  endproperty

  presence_pulse_a: assert property (resetToPresence)
    else $error("presence pulse timing wrong");

  stab_to_run_a: assert property (@(posedge ref_clk) disable iff (srst)
    stabDone && !modeProg_reg |=> runMode && pinOe && workCount_reg == $past(nvCount_reg))
    else $error("operating start wrong");

  prog_entry_a: assert property (@(posedge ref_clk) disable iff (srst)
    stabDone && modeProg_reg |=> (state_reg == osc_div_pkg::ST_PIDLE && !pinOe) [*3])
    else $error("programming entry wrong");

  por_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
    state_reg == osc_div_pkg::ST_POR |-> !pinOe && workCount_reg == `COUNT_MAX)
    else $error("pin driven before stabilisation");

  run_stable_a: assert property (@(posedge ref_clk) disable iff (srst)
    runMode ##1 runMode |-> $stable(workCount_reg) && $stable(workPrescale_reg))
    else $error("working words changed while running");

  commit_word_a: assert property (@(posedge ref_clk) disable iff (srst)
    commitNow && !factoryInit ##1 !factoryInit |->
    (isPrescale_reg ? nvPrescale_reg : nvCount_reg) == $past(commitData))
    else $error("write not committed");

  bad_cmd_a: assert property (@(posedge ref_clk) disable iff (srst)
    cmdDone && !(cmdByte inside {`CMD_WR_COUNT, `CMD_WR_PRESCALE, `CMD_RD_COUNT,
    `CMD_RD_PRESCALE}) |=> state_reg == osc_div_pkg::ST_IGNORE && !pinOe)
    else $error("unknown command not ignored");

  read_decode_a: assert property (@(posedge ref_clk) disable iff (srst)
    cmdDone && cmdByte == `CMD_RD_PRESCALE |=>
    state_reg == osc_div_pkg::ST_DATA && isRead_reg && shift_reg == $past(nvPrescale_reg))
    else $error("prescale read not set up");

  write_decode_a: assert property (@(posedge ref_clk) disable iff (srst)
    cmdDone && cmdByte == `CMD_WR_COUNT |=>
    state_reg == osc_div_pkg::ST_DATA && !isRead_reg && !isPrescale_reg)
    else $error("count write not set up");

  divider_high_a: assert property (@(posedge ref_clk) disable iff (srst)
    runMode && periodCnt_reg == 12'h000 ##1 runMode |-> clkOut_reg && pinOut || directOn)
    else $error("divider output phase wrong");
endmodule
